// *** src/effe_map.vh ***
// Constants for the Ethernet frame format engine
`ifndef EFFE_MAP_VH
`define EFFE_MAP_VH

// Register byte offsets
`define EFFE_OFS_CFG      8'h00
`define EFFE_OFS_STATUS   8'h04
`define EFFE_OFS_RXFRAMES 8'h08
`define EFFE_OFS_RXBAD    8'h0C

// Configuration fields
`define EFFE_CFG_TX_FCS_USER 0
`define EFFE_CFG_RX_FCS_PASS 1
`define EFFE_CFG_LEN_CHECK   2
`define EFFE_CFG_JUMBO       3
`define EFFE_CFG_RESET       4'h0

// Status fields
`define EFFE_ST_BAD      0
`define EFFE_ST_FCS_ERR  1
`define EFFE_ST_RUNT     2
`define EFFE_ST_OVERSIZE 3
`define EFFE_ST_LEN_ERR  4
`define EFFE_ST_MCAST    5
`define EFFE_ST_BCAST    6
`define EFFE_ST_VLAN     7
`define EFFE_ST_PAUSE    8
`define EFFE_ST_TYPE     9

// Framing values
`define EFFE_PREAMBLE     8'h55
`define EFFE_SFD          8'hD5
`define EFFE_PRE_LAST     4'h6
`define EFFE_TYPE_MIN     16'h0600
`define EFFE_VLAN_TYPE    16'h8100
`define EFFE_PAUSE_TYPE   16'h8808
`define EFFE_MIN_FRAME    16'h0040
`define EFFE_MIN_NOFCS    16'h003C
`define EFFE_MAX_FRAME    16'h05EE
`define EFFE_MAX_VLAN     16'h05F2
`define EFFE_HDR_FCS      16'h0012
`define EFFE_HDR_LEN      16'h000E
`define EFFE_MIN_DATA     16'h002E
`define EFFE_CRC_INIT     32'hFFFF_FFFF
`define EFFE_CRC_RESIDUE  32'hDEBB_20E3
`define EFFE_CRC_POLY     32'hEDB8_8320

`endif

// *** src/effe_crc8.v ***
// Byte-wide CRC-32 update, reflected form
`timescale 1ns/10ps
`include "effe_map.vh"

module effe_crc8 (
    input  wire [31:0] crc_in,
    input  wire [7:0]  data,
    output reg  [31:0] crc_out
);

    integer i;

    // LSB of each byte enters first, matching wire order
    always @* begin
        crc_out = crc_in;
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_out[0] ^ data[i]) begin
                crc_out = (crc_out >> 1) ^ `EFFE_CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end

endmodule

// *** src/effe_top.v ***
// Ethernet frame format engine: transmit framing, receive checking, register slave
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "effe_map.vh"

module effe_top #(
    parameter CNT_W = 16
) (
    input  wire        clk,
    input  wire        srst,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [7:0]  tx_data,
    input  wire        tx_valid,
    input  wire        tx_last,
    output reg         tx_ready,
    output reg  [7:0]  phy_txd,
    output reg         phy_tx_en,
    output reg         phy_tx_er,
    input  wire [7:0]  phy_rxd,
    input  wire        phy_rx_dv,
    output reg  [7:0]  rx_data,
    output reg         rx_valid,
    output reg         rx_last,
    output reg         rx_user
);

    localparam T_IDLE = 3'd0;
    localparam T_PRE  = 3'd1;
    localparam T_SFD  = 3'd2;
    localparam T_DATA = 3'd3;
    localparam T_PAD  = 3'd4;
    localparam T_FCS  = 3'd5;

    localparam R_IDLE = 2'd0;
    localparam R_DATA = 2'd1;
    localparam R_DROP = 2'd2;

    // Register file
    reg  [3:0]  cfg_q;
    reg  [9:0]  status_q;
    reg  [31:0] rx_frames_q;
    reg  [31:0] rx_bad_q;
    wire        wb_req;

    // Transmit state
    reg  [2:0]       tx_state_q;
    reg  [3:0]       pre_cnt_q;
    reg  [CNT_W-1:0] tx_cnt_q;
    reg  [1:0]       fcs_cnt_q;
    reg  [31:0]      tx_crc_q;
    reg              tx_fcs_user_q;
    wire [31:0]      tx_crc_d;
    wire [7:0]       tx_crc_byte;
    wire             tx_take;

    // Receive state
    reg  [7:0]       rxd_s1_q;
    reg  [7:0]       rxd_s2_q;
    reg              dv_s1_q;
    reg              dv_s2_q;
    reg  [1:0]       rx_state_q;
    reg  [CNT_W-1:0] rx_cnt_q;
    reg  [31:0]      rx_crc_q;
    wire [31:0]      rx_crc_d;
    reg  [31:0]      fcs_dly_q;
    reg  [7:0]       pend_q;
    reg              pend_v_q;
    reg  [15:0]      lt_q;
    reg              mcast_q;
    reg              bcast_q;
    reg              pass_q;
    reg              len_chk_q;
    reg              jumbo_q;

    // Delivery decision for the byte leaving the FCS delay
    reg              del_v;
    reg  [7:0]       del_b;
    reg  [CNT_W-1:0] del_idx;
    reg              strip;

    // End-of-frame checks
    wire             is_len;
    wire             is_vlan;
    wire             is_pause;
    wire [CNT_W-1:0] data_len;
    wire             fcs_err;
    wire             runt;
    wire             oversize;
    wire             len_err;
    wire             frame_err;

    // ------------------------------------------------------------------
    // Wishbone classic slave, one wait state, ack one cycle wide
    // ------------------------------------------------------------------
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            cfg_q    <= `EFFE_CFG_RESET;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && wb_we_i) begin
                if (wb_adr_i == `EFFE_OFS_CFG && wb_sel_i[0]) begin
                    cfg_q <= wb_dat_i[3:0];
                end
            end
            if (wb_req && !wb_we_i) begin
                // Unmapped offsets read zero and still ack
                case (wb_adr_i)
                    `EFFE_OFS_CFG:      wb_dat_o <= {28'h000_0000, cfg_q};
                    `EFFE_OFS_STATUS:   wb_dat_o <= {22'h00_0000, status_q};
                    `EFFE_OFS_RXFRAMES: wb_dat_o <= rx_frames_q;
                    `EFFE_OFS_RXBAD:    wb_dat_o <= rx_bad_q;
                    default:            wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit framing
    // ------------------------------------------------------------------
    assign tx_take     = tx_valid & tx_ready;
    assign tx_crc_byte = (tx_state_q == T_PAD) ? 8'h00 : tx_data;

    effe_crc8 u_tx_crc (
        .crc_in  (tx_crc_q),
        .data    (tx_crc_byte),
        .crc_out (tx_crc_d)
    );

    always @(posedge clk) begin
        if (srst) begin
            tx_state_q    <= T_IDLE;
            pre_cnt_q     <= 4'h0;
            tx_cnt_q      <= {CNT_W{1'b0}};
            fcs_cnt_q     <= 2'd0;
            tx_crc_q      <= `EFFE_CRC_INIT;
            tx_fcs_user_q <= 1'b0;
            tx_ready      <= 1'b0;
            phy_txd       <= 8'h00;
            phy_tx_en     <= 1'b0;
            phy_tx_er     <= 1'b0;
        end else begin
            phy_tx_er <= 1'b0;
            case (tx_state_q)
                T_IDLE: begin
                    phy_tx_en <= 1'b0;
                    phy_txd   <= 8'h00;
                    pre_cnt_q <= 4'h0;
                    tx_fcs_user_q <= cfg_q[`EFFE_CFG_TX_FCS_USER];
                    if (tx_valid) begin
                        tx_state_q <= T_PRE;
                    end
                end
                T_PRE: begin
                    phy_txd   <= `EFFE_PREAMBLE;
                    phy_tx_en <= 1'b1;
                    pre_cnt_q <= pre_cnt_q + 4'h1;
                    if (pre_cnt_q == `EFFE_PRE_LAST) begin
                        tx_state_q <= T_SFD;
                    end
                end
                T_SFD: begin
                    phy_txd    <= `EFFE_SFD;
                    tx_state_q <= T_DATA;
                    tx_ready   <= 1'b1;
                    tx_cnt_q   <= {CNT_W{1'b0}};
                    tx_crc_q   <= `EFFE_CRC_INIT;
                end
                T_DATA: begin
                    if (tx_take) begin
                        phy_txd  <= tx_data;
                        tx_crc_q <= tx_crc_d;
                        tx_cnt_q <= tx_cnt_q + 1'b1;
                        if (tx_last) begin
                            tx_ready  <= 1'b0;
                            fcs_cnt_q <= 2'd0;
                            if (tx_fcs_user_q) begin
                                tx_state_q <= T_IDLE;
                            end else if (tx_cnt_q < `EFFE_MIN_NOFCS - 16'h0001) begin
                                tx_state_q <= T_PAD;
                            end else begin
                                tx_state_q <= T_FCS;
                            end
                        end
                    end else begin
                        // Underrun mid-frame cannot be hidden; mark it
                        phy_txd   <= 8'h00;
                        phy_tx_er <= 1'b1;
                    end
                end
                T_PAD: begin
                    phy_txd  <= 8'h00;
                    tx_crc_q <= tx_crc_d;
                    tx_cnt_q <= tx_cnt_q + 1'b1;
                    if (tx_cnt_q == `EFFE_MIN_NOFCS - 16'h0001) begin
                        tx_state_q <= T_FCS;
                    end
                end
                T_FCS: begin
                    // low reflected byte first puts x31 first on the wire
                    phy_txd   <= ~tx_crc_q[7:0];
                    tx_crc_q  <= {8'h00, tx_crc_q[31:8]};
                    fcs_cnt_q <= fcs_cnt_q + 2'd1;
                    if (fcs_cnt_q == 2'd3) begin
                        tx_state_q <= T_IDLE;
                    end
                end
                default: begin
                    tx_state_q <= T_IDLE;
                    tx_ready   <= 1'b0;
                    phy_tx_en  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receive checking
    // ------------------------------------------------------------------
    // Pin synchronisers
    always @(posedge clk) begin
        if (srst) begin
            rxd_s1_q <= 8'h00;
            rxd_s2_q <= 8'h00;
            dv_s1_q  <= 1'b0;
            dv_s2_q  <= 1'b0;
        end else begin
            rxd_s1_q <= phy_rxd;
            rxd_s2_q <= rxd_s1_q;
            dv_s1_q  <= phy_rx_dv;
            dv_s2_q  <= dv_s1_q;
        end
    end

    effe_crc8 u_rx_crc (
        .crc_in  (rx_crc_q),
        .data    (rxd_s2_q),
        .crc_out (rx_crc_d)
    );

    assign is_len   = lt_q < `EFFE_TYPE_MIN;
    assign is_vlan  = lt_q == `EFFE_VLAN_TYPE;
    assign is_pause = lt_q == `EFFE_PAUSE_TYPE;
    assign data_len = rx_cnt_q - `EFFE_HDR_FCS;
    assign fcs_err  = rx_crc_q != `EFFE_CRC_RESIDUE;
    assign runt     = rx_cnt_q < `EFFE_MIN_FRAME;
    assign oversize = ~jumbo_q &
                      (rx_cnt_q > (is_vlan ? `EFFE_MAX_VLAN : `EFFE_MAX_FRAME));
    // length against data size; padded frames may exceed it
    assign len_err  = len_chk_q & is_len & ~runt &
                      ((lt_q > data_len) |
                       ((data_len > `EFFE_MIN_DATA) & (lt_q != data_len)));
    assign frame_err = fcs_err | runt | oversize | len_err;

    always @* begin
        // FCS bytes held back unless forwarded
        del_v   = pass_q | (rx_cnt_q >= 16'h0004);
        del_b   = pass_q ? rxd_s2_q : fcs_dly_q[31:24];
        del_idx = pass_q ? rx_cnt_q : rx_cnt_q - 16'h0004;
        // pad bytes beyond stated length dropped unless FCS forwarded
        strip   = ~pass_q & is_len & (del_idx >= lt_q + `EFFE_HDR_LEN);
    end

    always @(posedge clk) begin
        if (srst) begin
            rx_state_q  <= R_IDLE;
            rx_cnt_q    <= {CNT_W{1'b0}};
            rx_crc_q    <= `EFFE_CRC_INIT;
            fcs_dly_q   <= 32'h0000_0000;
            pend_q      <= 8'h00;
            pend_v_q    <= 1'b0;
            lt_q        <= 16'h0000;
            mcast_q     <= 1'b0;
            bcast_q     <= 1'b0;
            pass_q      <= 1'b0;
            len_chk_q   <= 1'b0;
            jumbo_q     <= 1'b0;
            status_q    <= 10'h000;
            rx_frames_q <= 32'h0000_0000;
            rx_bad_q    <= 32'h0000_0000;
            rx_data     <= 8'h00;
            rx_valid    <= 1'b0;
            rx_last     <= 1'b0;
            rx_user     <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            rx_last  <= 1'b0;
            rx_user  <= 1'b0;
            case (rx_state_q)
                R_IDLE: begin
                    if (dv_s2_q) begin
                        if (rxd_s2_q == `EFFE_SFD) begin
                            rx_state_q <= R_DATA;
                            rx_cnt_q   <= {CNT_W{1'b0}};
                            rx_crc_q   <= `EFFE_CRC_INIT;
                            pend_v_q   <= 1'b0;
                            lt_q       <= 16'h0000;
                            bcast_q    <= 1'b1;
                            pass_q     <= cfg_q[`EFFE_CFG_RX_FCS_PASS];
                            len_chk_q  <= cfg_q[`EFFE_CFG_LEN_CHECK];
                            jumbo_q    <= cfg_q[`EFFE_CFG_JUMBO];
                        end else if (rxd_s2_q != `EFFE_PREAMBLE) begin
                            rx_state_q <= R_DROP;
                        end
                    end
                end
                R_DATA: begin
                    if (dv_s2_q) begin
                        rx_crc_q  <= rx_crc_d;
                        fcs_dly_q <= {fcs_dly_q[23:0], rxd_s2_q};
                        if (rx_cnt_q != {CNT_W{1'b1}}) begin
                            rx_cnt_q <= rx_cnt_q + 1'b1;
                        end
                        if (rx_cnt_q == 16'h0000) begin
                            mcast_q <= rxd_s2_q[0];
                        end
                        if (rx_cnt_q < 16'h0006 && rxd_s2_q != 8'hFF) begin
                            bcast_q <= 1'b0;
                        end
                        if (rx_cnt_q == 16'h000C) begin
                            lt_q[15:8] <= rxd_s2_q;
                        end
                        if (rx_cnt_q == 16'h000D) begin
                            lt_q[7:0] <= rxd_s2_q;
                        end
                        if (del_v && !strip) begin
                            pend_q   <= del_b;
                            pend_v_q <= 1'b1;
                            if (pend_v_q) begin
                                rx_data  <= pend_q;
                                rx_valid <= 1'b1;
                            end
                        end
                    end else begin
                        // last and error with final byte after checks
                        rx_state_q <= R_IDLE;
                        rx_data    <= pend_v_q ? pend_q : 8'h00;
                        rx_valid   <= 1'b1;
                        rx_last    <= 1'b1;
                        rx_user    <= frame_err;
                        pend_v_q   <= 1'b0;
                        status_q   <= {~is_len, is_pause, is_vlan, bcast_q, mcast_q,
                                       len_err, oversize, runt, fcs_err, frame_err};
                        rx_frames_q <= rx_frames_q + 32'h0000_0001;
                        if (frame_err) begin
                            rx_bad_q <= rx_bad_q + 32'h0000_0001;
                        end
                    end
                end
                R_DROP: begin
                    // Garbage before the delimiter; wait for carrier to end
                    if (!dv_s2_q) begin
                        rx_state_q <= R_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= R_IDLE;
                end
            endcase
        end
    end

endmodule

// *** tb/effe_sva.sv ***
// Port checker for the frame format engine
`timescale 1ns/10ps
module effe_sva (
    input wire        clk,
    input wire        srst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [7:0]  tx_data,
    input wire        tx_valid,
    input wire        tx_ready,
    input wire [7:0]  phy_txd,
    input wire        phy_tx_en,
    input wire        phy_rx_dv,
    input wire        rx_valid,
    input wire        rx_last,
    input wire        rx_user
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_pre;
        $rose(phy_tx_en) |-> (phy_txd == 8'h55)[*7];
    endproperty
    a_pre: assert property (p_pre) else $error("preamble byte wrong");
    property p_sfd;
        $rose(phy_tx_en) |-> ##7 phy_txd == 8'hD5;
    endproperty
    a_sfd: assert property (p_sfd) else $error("delimiter wrong");
    property p_rdy_pre;
        $rose(phy_tx_en) |-> !tx_ready[*7];
    endproperty
    a_rdy_pre: assert property (p_rdy_pre) else $error("ready in preamble");
    property p_rdy_en;
        tx_ready |-> phy_tx_en;
    endproperty
    a_rdy_en: assert property (p_rdy_en) else $error("ready outside frame");
    property p_tx_pass;
        tx_valid && tx_ready |=> phy_tx_en && phy_txd == $past(tx_data);
    endproperty
    a_tx_pass: assert property (p_tx_pass) else $error("byte altered");
    property p_user_last;
        rx_user |-> rx_last && rx_valid;
    endproperty
    a_user_last: assert property (p_user_last) else $error("error flag alone");
    property p_last_valid;
        rx_last |-> rx_valid;
    endproperty
    a_last_valid: assert property (p_last_valid) else $error("last without byte");
    property p_rx_quiet;
        !phy_rx_dv[*8] |-> !rx_valid;
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("byte without frame");
    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    c_tx: cover property ($rose(phy_tx_en));
    c_rx_ok: cover property (rx_last && !rx_user);
    c_rx_bad: cover property (rx_user);
endmodule

bind effe_top effe_sva effe_sva_i (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .phy_txd(phy_txd), .phy_tx_en(phy_tx_en),
    .phy_rx_dv(phy_rx_dv), .rx_valid(rx_valid), .rx_last(rx_last), .rx_user(rx_user));

// *** tb/effe_phy_model.sv ***
// PHY-side model: records transmit bytes, plays receive bytes
`timescale 1ns/10ps
module effe_phy_model (
    input  wire        clk,
    input  wire [7:0]  phy_txd,
    input  wire        phy_tx_en,
    output logic [7:0] phy_rxd,
    output logic       phy_rx_dv
);
    logic [7:0] txq[$];
    initial begin
        phy_rxd = 8'h00;
        phy_rx_dv = 1'b0;
    end
    always @(posedge clk) if (phy_tx_en === 1'b1) txq.push_back(phy_txd);
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge clk);
            phy_rxd <= q[i];
            phy_rx_dv <= 1'b1;
        end
        @(posedge clk);
        // Idle bus shows the inverse, never the stale byte
        phy_rxd <= ~phy_rxd;
        phy_rx_dv <= 1'b0;
    endtask
endmodule

// *** tb/effe_top_test.sv ***
// Self-checking bench for the frame format engine
`timescale 1ns/10ps
`include "effe_map.vh"
module effe_top_test;
    logic        clk, srst, wb_we_i, wb_cyc_i, wb_stb_i, tx_valid, tx_last, rx_end, rx_bad;
    logic [7:0]  wb_adr_i, tx_data;
    logic [31:0] wb_dat_i, rd;
    logic [3:0]  wb_sel_i;
    logic [7:0]  fr[$], ex[$], rxq[$];
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, tx_ready, phy_tx_en, phy_tx_er, phy_rx_dv;
    wire         rx_valid, rx_last, rx_user;
    wire  [7:0]  phy_txd, phy_rxd, rx_data;
    int          num_errors = 0;
    int          n_tests = 0;
    effe_top effe_top_i (.clk(clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .phy_txd(phy_txd), .phy_tx_en(phy_tx_en),
        .phy_tx_er(phy_tx_er), .phy_rxd(phy_rxd), .phy_rx_dv(phy_rx_dv),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_user(rx_user));
    effe_phy_model effe_phy_model_i (.clk(clk), .phy_txd(phy_txd), .phy_tx_en(phy_tx_en),
        .phy_rxd(phy_rxd), .phy_rx_dv(phy_rx_dv));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] fcs(input logic [7:0] q[$]);
        logic [31:0] c;
        c = `EFFE_CRC_INIT;
        foreach (q[i]) begin
            c ^= {24'h0, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `EFFE_CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int k;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        chk(wb_ack_o, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_regs;
        wb(1, `EFFE_OFS_CFG, 32'h0000_000F, 4'h1);
        wb(1, `EFFE_OFS_CFG, 32'h0000_0000, 4'h0);
        wb(1, `EFFE_OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
        wb(0, `EFFE_OFS_STATUS, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000);
        wb(0, `EFFE_OFS_CFG, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_000F);
        wb(0, 8'h10, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000);
        wb(1, `EFFE_OFS_CFG, 32'h0000_0000, 4'h1);
    endtask
    task automatic t_tx(input int n, input bit user);
        int i, k;
        logic [31:0] c;
        // user mode: no pad, no FCS
        wb(1, `EFFE_OFS_CFG, {31'h0, user}, 4'h1);
        fr = {};
        for (i = 0; i < 12; i++) fr.push_back(i < 6 ? 8'hFF : 8'h10 + i[7:0]);
        fr.push_back(8'h00);
        fr.push_back(n[7:0]);
        for (i = 0; i < n; i++) fr.push_back(8'hA0 + i[7:0]);
        ex = {};
        repeat (7) ex.push_back(8'h55);
        ex.push_back(8'hD5);
        ex = {ex, fr};
        if (!user) begin
            while (ex.size() < 68) ex.push_back(8'h00);
            c = fcs(ex[8:$]);
            for (i = 0; i < 4; i++) ex.push_back(c[8*i +: 8]);
        end
        effe_phy_model_i.txq = {};
        tx_data <= fr[0];
        tx_valid <= 1'b1;
        i = 0;
        k = 0;
        while (i < fr.size() && k < 200) begin
            @(posedge clk);
            k++;
            chk(phy_tx_er, 1'b0);
            if (tx_ready === 1'b1) begin
                i++;
                tx_data <= i < fr.size() ? fr[i] : 8'h00;
                tx_last <= i == fr.size() - 1;
                tx_valid <= i < fr.size();
            end
        end
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (phy_tx_en !== 1'b0 && k < 200);
        chk(i, fr.size());
        chk(phy_tx_en, 1'b0);
        chk(effe_phy_model_i.txq.size(), ex.size());
        foreach (ex[j]) chk(effe_phy_model_i.txq[j], ex[j]);
    endtask
    task automatic rx_wait;
        int k;
        k = 0;
        while (rx_end !== 1'b1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        chk(rx_end, 1'b1);
    endtask
    task automatic t_rx(input logic [3:0] cfg, input int s, input bit bad);
        logic [7:0] q[$];
        wb(1, `EFFE_OFS_CFG, {28'h0, cfg}, 4'h1);
        q = ex[s:$];
        if (bad) q[$] = ~q[$];
        rxq = {};
        rx_end = 1'b0;
        effe_phy_model_i.send(q);
        rx_wait;
        chk(rxq.size(), cfg[1] ? 64 : fr.size());
        foreach (rxq[j]) chk(rxq[j], cfg[1] ? ex[8+j] : fr[j]);
        chk(rx_bad, bad);
        wb(0, `EFFE_OFS_STATUS, 32'h0000_0000, 4'hF);
        chk(rd & 32'h0000_0063, bad ? 32'h0000_0063 : 32'h0000_0060);
    endtask
    task automatic t_rx_chk(input logic [3:0] cfg, input logic [15:0] lt, input int n,
                            input int nd, input logic [9:0] st);
        logic [7:0] q[$];
        logic [31:0] c;
        int i;
        wb(1, `EFFE_OFS_CFG, {28'h0, cfg}, 4'h1);
        q = {};
        for (i = 0; i < 12; i++) q.push_back(i[7:0]);
        q.push_back(lt[15:8]);
        q.push_back(lt[7:0]);
        for (i = 0; i < n; i++) q.push_back(8'hC0 ^ i[7:0]);
        c = fcs(q);
        for (i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
        q.push_front(8'hD5);
        rxq = {};
        rx_end = 1'b0;
        effe_phy_model_i.send(q);
        rx_wait;
        chk(rxq.size(), nd);
        foreach (rxq[j]) chk(rxq[j], q[j+1]);
        chk(rx_bad, st[0]);
        wb(0, `EFFE_OFS_STATUS, 32'h0000_0000, 4'hF);
        chk(rd, {22'h0, st});
    endtask
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rxq.push_back(rx_data);
            if (rx_last === 1'b1) begin
                rx_end <= 1'b1;
                rx_bad <= rx_user;
            end
        end
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        // reset made apart from the engine
        srst = 1'b1;
        {wb_we_i, wb_cyc_i, wb_stb_i, tx_valid, tx_last, rx_end, rx_bad} = 7'h00;
        {wb_adr_i, tx_data, wb_sel_i} = 20'h0_0000;
        wb_dat_i = 32'h0000_0000;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_tx(5, 1'b1);
        t_tx(5, 1'b0);
        t_rx(4'h0, 0, 0);
        t_rx(4'h2, 7, 0);
        t_rx(4'h4, 0, 1);
        t_rx_chk(4'h0, 16'h0800, 10, 24, 10'h205);
        t_rx_chk(4'h4, 16'h0030, 50, 62, 10'h011);
        t_rx_chk(4'h0, 16'h8100, 46, 60, 10'h280);
        t_rx_chk(4'h0, 16'h8808, 46, 60, 10'h300);
        t_rx_chk(4'h0, 16'h0800, 1505, 1519, 10'h209);
        t_rx_chk(4'h8, 16'h0800, 1505, 1519, 10'h200);
        wb(0, `EFFE_OFS_RXFRAMES, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0009);
        wb(0, `EFFE_OFS_RXBAD, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0004);
        tally_and_finish;
    end
    initial begin
        #200_000;
        num_errors++;
        tally_and_finish;
    end
endmodule
